// >>> hw/ccp_pkg.sv
// shared constants and types for the camera control serial slave
// assumes a core clock (mclk) and a fast link sampling clock beside it

package ccp_pkg;

	// ----------------------------------------------------------------
	// clocks
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	// span of input_clock_frequency for fast-mode-plus operation
	localparam int FREQ_MIN_KHZ = 11_400;
	localparam int FREQ_MAX_KHZ = 27_000;

	// ----------------------------------------------------------------
	// register address areas
	// ----------------------------------------------------------------
	localparam logic [15:0] CFG_BASE = 16'h0000;
	localparam logic [15:0] CFG_LAST = 16'h0FFF;
	localparam logic [15:0] LIMIT_BASE = 16'h1000;
	localparam logic [15:0] LIMIT_LAST = 16'h1FFF;
	localparam logic [15:0] MFG_BASE = 16'h3000;

	// ----------------------------------------------------------------
	// protocol values and reset values
	// ----------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR_DEF = 7'h10;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [15:0] IDX_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {AREA_CFG, AREA_LIMIT, AREA_GAP, AREA_MFG} area_e;
	typedef enum logic [2:0] {L_IDLE, L_RECV, L_ACK, L_SEND, L_MACK, L_WAIT}
		link_st_e;
	typedef enum logic [1:0] {PH_ADDR, PH_HI, PH_LO, PH_DATA} phase_e;

	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} acc_req_s;

	function automatic area_e area_of(input logic [15:0] a);
		area_e r;
		if (a <= CFG_LAST)
			r = AREA_CFG;
		else if (a <= LIMIT_LAST)
			r = AREA_LIMIT;
		else if (a >= MFG_BASE)
			r = AREA_MFG;
		else
			r = AREA_GAP;
		return r;
	endfunction

endpackage

// >>> hw/camera_control_serial_slave.sv
// two-wire control slave of an image sensor with its register store
// assumes scl/sda from an open-drain bus, link_clk far faster than scl

`timescale 1ns/1ps
`default_nettype none

// What this block does
// - messages carry a two-byte register address, then eight-bit data units.
// - every byte moves most significant bit first, one bit per scl cycle.
// - the receiver answers each byte with ack or nack in the next cycle.
// - the sender changes sda only while scl is low.
// - sda falling while scl is high is a start.
// - a start without a preceding stop is a repeated start; index kept.
// - sda rising while scl is high is a stop.
// - direction bit after slave address: 0 writes, 1 reads.
// - after sending ack or nack, a party releases sda, except the slave after a read address ack, which drives the first data bit.
// - areas: configuration to 0x0FFF, limits 0x1000-0x1FFF, vendor from 0x3000.
// - behaves as fast-mode-plus slave for input clock 11.4 to 27 MHz.
// - master may read and write control registers and read status ones.
// - index advances by one at every data ack or nack.
// - a read without address phase returns data at the held index.
module camera_control_serial_slave #(
	parameter logic [6:0] SLAVE_ADDR = ccp_pkg::SLAVE_ADDR_DEF,
	parameter int CFG_DEPTH = 16,
	parameter int MFG_DEPTH = 16,
	parameter int LIMIT_DEPTH = 4,
	parameter logic [LIMIT_DEPTH*8-1:0] LIMIT_TABLE = '0
) (
	input wire logic mclk, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic link_clk, // pin sampling clock
	input wire logic scl, // serial clock pin
	input wire logic sda_i, // serial data pin level
	output logic sda_o, // serial data drive value
	output logic sda_oe, // high while pulling sda
	output logic [CFG_DEPTH*8-1:0] cfg_q // configuration bytes
);

	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	if (CFG_DEPTH < 1 || CFG_DEPTH > 4096) begin : g_bad_cfg
		$error("CFG_DEPTH must be 1..4096");
	end
	if (MFG_DEPTH < 1 || MFG_DEPTH > 4096) begin : g_bad_mfg
		$error("MFG_DEPTH must be 1..4096");
	end
	if (LIMIT_DEPTH < 1 || LIMIT_DEPTH > 4096) begin : g_bad_lim
		$error("LIMIT_DEPTH must be 1..4096");
	end

	// ----------------------------------------------------------------
	// link domain reset and pin synchronisers
	// ----------------------------------------------------------------
	logic lrst_q1_r, lrst_n;
	logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			lrst_q1_r <= 1'b0;
			lrst_n <= 1'b0;
		end else begin
			lrst_q1_r <= 1'b1;
			lrst_n <= lrst_q1_r;
		end
	end

	// pins sampled on link_clk, so scl edges are seen on it; read data still crosses over from mclk
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_m_r <= scl;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= sda_i;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
		end
	end

	logic scl_rise, scl_fall, start_ev, stop_ev;
	assign scl_rise = scl_s_r & ~scl_d_r;
	assign scl_fall = ~scl_s_r & scl_d_r;
	assign start_ev = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	assign stop_ev = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

	// ----------------------------------------------------------------
	// link state machine
	// ----------------------------------------------------------------
	ccp_pkg::link_st_e st_r;
	ccp_pkg::phase_e ph_r;
	logic [3:0] cnt_r;
	logic [7:0] sh_r, tx_r, hi_r, rdata_l_r;
	logic [15:0] idx_r;
	logic rd_mode_r;

	logic byte_in, addr_hit, take_ack, mack_rise;
	assign byte_in = (st_r == ccp_pkg::L_RECV) && scl_fall
		&& (cnt_r == ccp_pkg::BITS_PER_BYTE);
	assign addr_hit = (sh_r[7:1] == SLAVE_ADDR);
	assign take_ack = byte_in && (ph_r != ccp_pkg::PH_ADDR || addr_hit);
	assign mack_rise = (st_r == ccp_pkg::L_MACK) && scl_rise;

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			st_r <= ccp_pkg::L_IDLE;
			ph_r <= ccp_pkg::PH_ADDR;
			cnt_r <= 4'h0;
			sh_r <= ccp_pkg::BYTE_RESET;
			tx_r <= ccp_pkg::BYTE_RESET;
			rd_mode_r <= ccp_pkg::DIR_WRITE;
			sda_oe <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
			if (start_ev) begin
				st_r <= ccp_pkg::L_RECV;
				ph_r <= ccp_pkg::PH_ADDR;
				cnt_r <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop_ev) begin
				st_r <= ccp_pkg::L_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (st_r)
				ccp_pkg::L_RECV: begin
					if (scl_rise) begin
						sh_r <= {sh_r[6:0], sda_s_r};
						cnt_r <= 4'(cnt_r + 4'h1);
					end else if (byte_in) begin
						cnt_r <= 4'h0;
						if (take_ack) begin
							st_r <= ccp_pkg::L_ACK;
							sda_oe <= 1'b1;
							if (ph_r == ccp_pkg::PH_ADDR)
								rd_mode_r <= sh_r[0];
						end else begin
							// foreign slave address: stay off the bus
							st_r <= ccp_pkg::L_IDLE;
						end
					end
				end
				ccp_pkg::L_ACK: begin
					if (scl_fall) begin
						if (rd_mode_r == ccp_pkg::DIR_READ) begin
							// first data bit goes out on the ack fall
							st_r <= ccp_pkg::L_SEND;
							sda_oe <= ~rdata_l_r[7];
							tx_r <= {rdata_l_r[6:0], 1'b0};
							cnt_r <= 4'h1;
						end else begin
							st_r <= ccp_pkg::L_RECV;
							sda_oe <= 1'b0;
							cnt_r <= 4'h0;
							case (ph_r)
							ccp_pkg::PH_ADDR: ph_r <= ccp_pkg::PH_HI;
							ccp_pkg::PH_HI: ph_r <= ccp_pkg::PH_LO;
							default: ph_r <= ccp_pkg::PH_DATA;
							endcase
						end
					end
				end
				ccp_pkg::L_SEND: begin
					if (scl_fall) begin
						if (cnt_r == ccp_pkg::BITS_PER_BYTE) begin
							st_r <= ccp_pkg::L_MACK;
							sda_oe <= 1'b0;
						end else begin
							sda_oe <= ~tx_r[7];
							tx_r <= {tx_r[6:0], 1'b0};
							cnt_r <= 4'(cnt_r + 4'h1);
						end
					end
				end
				ccp_pkg::L_MACK: begin
					if (scl_rise) begin
						if (!sda_s_r)
							st_r <= ccp_pkg::L_ACK;
						else
							st_r <= ccp_pkg::L_WAIT;
					end
				end
				default: begin
				end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// register index, untouched by starts so it holds across them
	// ----------------------------------------------------------------
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			idx_r <= ccp_pkg::IDX_RESET;
			hi_r <= ccp_pkg::BYTE_RESET;
		end else if (take_ack && !start_ev && !stop_ev) begin
			case (ph_r)
			ccp_pkg::PH_HI: hi_r <= sh_r;
			ccp_pkg::PH_LO: idx_r <= {hi_r, sh_r};
			ccp_pkg::PH_DATA: idx_r <= 16'(idx_r + 16'h0001);
			default: begin
			end
			endcase
		end else if (mack_rise && !start_ev && !stop_ev) begin
			idx_r <= 16'(idx_r + 16'h0001);
		end
	end

	// ----------------------------------------------------------------
	// access handshake, link side
	// ----------------------------------------------------------------
	ccp_pkg::acc_req_s req_r;
	logic req_tgl_r, ack_tgl_r, ack_m_r, ack_s_r, ack_d_r;
	logic [7:0] rdata_m_r;
	logic quiet;
	assign quiet = !start_ev && !stop_ev;

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			req_r <= '0;
			req_tgl_r <= 1'b0;
		end else if (quiet && take_ack && ph_r == ccp_pkg::PH_ADDR
				&& sh_r[0] == ccp_pkg::DIR_READ) begin
			req_r <= '{we: 1'b0, addr: idx_r, wdata: ccp_pkg::BYTE_RESET};
			req_tgl_r <= ~req_tgl_r;
		end else if (quiet && take_ack && ph_r == ccp_pkg::PH_DATA) begin
			req_r <= '{we: 1'b1, addr: idx_r, wdata: sh_r};
			req_tgl_r <= ~req_tgl_r;
		end else if (quiet && mack_rise && !sda_s_r) begin
			// prefetch next byte while scl is high
			req_r <= '{we: 1'b0, addr: 16'(idx_r + 16'h0001),
				wdata: ccp_pkg::BYTE_RESET};
			req_tgl_r <= ~req_tgl_r;
		end
	end

	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			ack_m_r <= 1'b0;
			ack_s_r <= 1'b0;
			ack_d_r <= 1'b0;
			rdata_l_r <= ccp_pkg::BYTE_RESET;
		end else begin
			ack_m_r <= ack_tgl_r;
			ack_s_r <= ack_m_r;
			ack_d_r <= ack_s_r;
			if (ack_s_r != ack_d_r)
				rdata_l_r <= rdata_m_r;
		end
	end

	// ----------------------------------------------------------------
	// register store on mclk
	// ----------------------------------------------------------------
	logic req_m_r, req_s_r, req_d_r, take;
	logic [7:0] mfg_r [MFG_DEPTH];
	logic [7:0] rd_val;
	assign take = req_s_r ^ req_d_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			req_m_r <= 1'b0;
			req_s_r <= 1'b0;
			req_d_r <= 1'b0;
		end else begin
			req_m_r <= req_tgl_r;
			req_s_r <= req_m_r;
			req_d_r <= req_s_r;
		end
	end

	// request fields are held steady by the link until the next toggle
	always_comb begin
		rd_val = ccp_pkg::UNMAPPED_DATA;
		case (ccp_pkg::area_of(req_r.addr))
		ccp_pkg::AREA_CFG:
			for (int i = 0; i < CFG_DEPTH; i++)
				if (req_r.addr == 16'(ccp_pkg::CFG_BASE + 16'(i)))
					rd_val = cfg_q[i*8 +: 8];
		ccp_pkg::AREA_LIMIT:
			for (int i = 0; i < LIMIT_DEPTH; i++)
				if (req_r.addr == 16'(ccp_pkg::LIMIT_BASE + 16'(i)))
					rd_val = LIMIT_TABLE[i*8 +: 8];
		ccp_pkg::AREA_MFG:
			for (int i = 0; i < MFG_DEPTH; i++)
				if (req_r.addr == 16'(ccp_pkg::MFG_BASE + 16'(i)))
					rd_val = mfg_r[i];
		default: begin
		end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= '0;
			for (int i = 0; i < MFG_DEPTH; i++)
				mfg_r[i] <= ccp_pkg::BYTE_RESET;
			rdata_m_r <= ccp_pkg::BYTE_RESET;
			ack_tgl_r <= 1'b0;
		end else if (take) begin
			ack_tgl_r <= ~ack_tgl_r;
			if (!req_r.we)
				rdata_m_r <= rd_val;
			// limit area has no store, so writes there fall away
			for (int i = 0; i < CFG_DEPTH; i++)
				if (req_r.we && req_r.addr == 16'(ccp_pkg::CFG_BASE + 16'(i)))
					cfg_q[i*8 +: 8] <= req_r.wdata;
			for (int i = 0; i < MFG_DEPTH; i++)
				if (req_r.we && req_r.addr == 16'(ccp_pkg::MFG_BASE + 16'(i)))
					mfg_r[i] <= req_r.wdata;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_addr_read;
		byte_in && ph_r == ccp_pkg::PH_ADDR && addr_hit && sh_r[0];
	endsequence

	start_enter_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		start_ev |=> st_r == ccp_pkg::L_RECV && ph_r == ccp_pkg::PH_ADDR
			&& !sda_oe)
		else $error("start not taken");
	stop_leave_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		stop_ev |=> st_r == ccp_pkg::L_IDLE && !sda_oe)
		else $error("stop not taken");
	start_keeps_index_a: assert property (@(posedge link_clk)
		disable iff (!lrst_n) start_ev |=> idx_r == $past(idx_r))
		else $error("index moved on start");
	drive_scl_low_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		($changed(sda_oe) && $past(quiet)) |-> !scl_s_r)
		else $error("sda changed while scl high");
	ack_drive_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(take_ack && quiet) |=> sda_oe && st_r == ccp_pkg::L_ACK)
		else $error("byte not acknowledged");
	ack_release_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(st_r == ccp_pkg::L_ACK && scl_fall && !rd_mode_r && quiet)
			|=> !sda_oe ##1 !sda_oe)
		else $error("sda held after ack");
	read_dir_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(s_addr_read and quiet) |=> rd_mode_r && req_tgl_r != $past(req_tgl_r))
		else $error("read direction missed");
	foreign_addr_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(byte_in && ph_r == ccp_pkg::PH_ADDR && !addr_hit && quiet)
			|=> st_r == ccp_pkg::L_IDLE && !sda_oe)
		else $error("answered foreign address");
	msb_first_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(st_r == ccp_pkg::L_SEND && scl_fall && cnt_r != 4'h8 && quiet)
			|=> sda_oe == !$past(tx_r[7]))
		else $error("bit order wrong");
	index_step_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
		(mack_rise && quiet) |=> idx_r == 16'($past(idx_r) + 16'h0001))
		else $error("index not advanced");
	limit_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && !req_r.we && req_r.addr == ccp_pkg::LIMIT_BASE)
			|=> rdata_m_r == LIMIT_TABLE[7:0] && ack_tgl_r != $past(ack_tgl_r))
		else $error("limit area read wrong");
	cfg_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(take && req_r.we && req_r.addr == ccp_pkg::CFG_BASE)
			|=> cfg_q[7:0] == $past(req_r.wdata))
		else $error("configuration write lost");

endmodule

`default_nettype wire

// >>> tb/ccp_master.sv
// host master model for the two-wire control port
// assumes the bench resolves sda with a pull-up; steps on mclk falls
`timescale 1ns/1ps
`default_nettype none

module ccp_master #(
	parameter int Q = 8
) (
	input wire logic mclk, // step clock
	input wire logic sda_w, // resolved sda level
	output logic scl, // serial clock, idle high
	output logic pull // high while pulling sda low
);
	// ----------------------------------------------------------------
	// bus primitives
	// ----------------------------------------------------------------
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end

	task automatic qw();
		repeat (Q) @(negedge mclk);
	endtask

	// sda moves only with scl low, sampled in mid high phase
	task automatic xbit(input logic b, output logic s);
		pull = ~b;
		qw();
		scl = 1'b1;
		qw();
		s = sda_w;
		qw();
		scl = 0;
		qw();
	endtask

	// releases sda first, so the same task serves a repeated start
	task automatic start();
		pull = 1'b0;
		qw();
		scl = 1'b1;
		qw();
		pull = 1'b1;
		qw();
		scl = 1'b0;
		qw();
	endtask

	task automatic stop();
		pull = 1'b1;
		qw();
		scl = 1'b1;
		qw();
		pull = 1'b0;
		qw();
	endtask

	task automatic send(input logic [7:0] d, output logic [7:0] e,
		output logic nak);
		for (int i = 7; i >= 0; i--)
			xbit(d[i], e[i]);
		xbit(1'b1, nak);
	endtask

	task automatic recv(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			xbit(1'b1, d[i]);
		xbit(last, s);
	endtask
endmodule

`default_nettype wire

// >>> tb/camera_control_serial_slave_tb.sv
// self-checking bench for the camera control serial slave
// assumes ccp_master as bus host and a pull-up on sda modelled here
`timescale 1ns/1ps
`default_nettype none

module camera_control_serial_slave_tb;
	localparam logic [31:0] LT = 32'h8844_21c3;
	localparam logic [15:0] BASE [4] = '{16'h0000, 16'h0ff8, 16'h2ffa,
		16'h3004};
	logic mclk, link_clk, rst_n, scl, pull, sda_w, sda_o, sda_oe;
	logic oe_hi = 1'b0;
	logic [127:0] cfg_q;
	logic [7:0] cfgm [16];
	logic [7:0] mfgm [16];
	logic [15:0] eidx, ra;
	logic [31:0] seed;
	int errors, checked, rn;

	// open drain: any puller wins over the pull-up
	assign sda_w = ~(sda_oe | pull);

	camera_control_serial_slave #(.LIMIT_TABLE(LT)) i_dut (.mclk(mclk),
		.rst_n(rst_n), .link_clk(link_clk), .scl(scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe(sda_oe), .cfg_q(cfg_q));
	ccp_master i_mst (.mclk(mclk), .sda_w(sda_w), .scl(scl), .pull(pull));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end

	// ----------------------------------------------------------------
	// checking helpers
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [127:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		if (errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	// unimplemented and gap addresses read as zero
	function automatic logic [7:0] exp_rd(input logic [15:0] a);
		if (a < 16'h0010)
			return cfgm[a[3:0]];
		if (a >= 16'h1000 && a < 16'h1004)
			return LT[a[1:0]*8 +: 8];
		if (a >= 16'h3000 && a < 16'h3010)
			return mfgm[a[3:0]];
		return 8'h00;
	endfunction

	function automatic logic [127:0] cfg_exp();
		logic [127:0] v;
		for (int i = 0; i < 16; i++)
			v[i*8 +: 8] = cfgm[i];
		return v;
	endfunction

	task automatic snd(input logic [7:0] d, input logic nak_exp);
		logic [7:0] e;
		logic nak;
		i_mst.send(d, e, nak);
		check("sda echo", e, d);
		check("ack bit", nak, nak_exp);
	endtask

	task automatic aph(input logic [15:0] a);
		i_mst.start();
		snd({ccp_pkg::SLAVE_ADDR_DEF, ccp_pkg::DIR_WRITE}, 1'b0);
		snd(a[15:8], 1'b0);
		snd(a[7:0], 1'b0);
		eidx = a;
	endtask

	task automatic wr(input logic [15:0] a, input int n);
		logic [7:0] d;
		aph(a);
		for (int k = 0; k < n; k++) begin
			seed = xs(seed);
			d = seed[7:0];
			snd(d, 1'b0);
			if (eidx < 16'h0010)
				cfgm[eidx[3:0]] = d;
			if (eidx >= 16'h3000 && eidx < 16'h3010)
				mfgm[eidx[3:0]] = d;
			eidx++;
		end
		i_mst.stop();
		repeat (8) @(negedge mclk);
		check("cfg_q", cfg_q, cfg_exp());
	endtask

	// after aph this start is a repeated one
	task automatic rd(input int n);
		logic [7:0] d;
		i_mst.start();
		snd({ccp_pkg::SLAVE_ADDR_DEF, ccp_pkg::DIR_READ}, 1'b0);
		for (int k = 0; k < n; k++) begin
			i_mst.recv(k == n - 1, d);
			check("read data", d, exp_rd(eidx));
			eidx++;
		end
		i_mst.stop();
		repeat (4) @(negedge mclk);
	endtask

	// slave drive must hold over each scl high phase
	always @(posedge scl)
		if (rst_n === 1'b1)
			oe_hi <= sda_oe;
	always @(negedge scl)
		if (rst_n === 1'b1) begin
			check("sda_oe in high phase", sda_oe, oe_hi);
			check("sda_o", sda_o, 1'b0);
		end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		seed = 32'h14d3_f888;
		errors = 0;
		checked = 0;
		for (int i = 0; i < 16; i++) begin
			cfgm[i] = 8'h00;
			mfgm[i] = 8'h00;
		end
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		check("cfg_q reset", cfg_q, '0);
		wr(16'h0000, 16);
		aph(16'h0005);
		rd(3);
		rd(2);
		wr(16'h0fff, 2);
		aph(16'h0ffe);
		rd(4);
		wr(16'h300e, 3);
		aph(16'h2ffe);
		rd(4);
		i_mst.start();
		snd({ccp_pkg::SLAVE_ADDR_DEF ^ 7'h01, ccp_pkg::DIR_WRITE}, 1'b1);
		i_mst.stop();
		rd(1);
		i_mst.start();
		snd({ccp_pkg::SLAVE_ADDR_DEF, ccp_pkg::DIR_WRITE}, 1'b0);
		snd(8'h30, 1'b0);
		i_mst.stop();
		rd(2);
		for (int j = 0; j < 14; j++) begin
			seed = xs(seed);
			ra = BASE[seed[9:8]] + {11'h000, seed[14:10]};
			rn = 1 + int'(seed[17:16]);
			if (seed[20])
				wr(ra, rn);
			else begin
				if (seed[21])
					aph(ra);
				rd(rn);
			end
		end
		wrap_up();
	end

	initial begin
		repeat (90000) @(posedge mclk);
		errors++;
		wrap_up();
	end
endmodule

`default_nettype wire
